// [logic/bps_supervisor.sv]
`default_nettype none
module bps_supervisor #(
  parameter longint unsigned WEEK_CYCLES = bps_pkg::WEEK_CYC,
  parameter int unsigned BUS_HOLD_CYCLES = bps_pkg::BUS_HOLD_CYC,
  parameter int unsigned WP_CYCLES = bps_pkg::WP_RECOVERY_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmp_main_below_so,
  input wire logic cmp_main_below_bat,
  input wire logic cmp_bat_low,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq_n_o,
  output logic irq_n_oe,
  output logic backup_mode,
  output logic pins_low,
  output logic func_gate_n,
  output logic rtc_clk_en,
  output logic input_enable,
  output logic write_protect,
  output logic serial_bus_enable
);
  bps_pkg::bps_cmp_t raw_s; // raw comparator inputs
  bps_pkg::bps_cmp_t cmp_s; // synchronised
  bps_pkg::bps_mode_t mode_q; // supply mode
  logic [7:0] ctrl_q; // control register
  logic [2:0] stat_q; // sticky events
  logic [2:0] mask_q; // event enables
  logic [2:0] ev; // event pulses this cycle
  logic bus_busy, bus_done, wp_busy, wp_done; // timer status
  logic swap_to_main; // one-cycle switch-back pulse
  logic [63:0] week_q; // weekly recheck counter
  logic week_tick; // week elapsed
  logic chk_pend_q; // power-up check outstanding
  logic low_flag_q; // low battery already reported
  logic batlow_ev; // battery low event
  logic irq_req; // interrupt condition
  logic bce; // battery check enable

  assign raw_s = '{main_below_so: cmp_main_below_so, main_below_bat: cmp_main_below_bat,
                   bat_low: cmp_bat_low};
  assign bce = ctrl_q[bps_pkg::CTRL_BCE_BIT];

  // comparator synchroniser
  bps_sync #(.W(3)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(raw_s),
    .q(cmp_s)
  );

  // supply mode machine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= bps_pkg::BPS_MAIN;
    end else begin
      unique case (mode_q)
        bps_pkg::BPS_MAIN: begin
          // both conditions together
          if (cmp_s.main_below_so && cmp_s.main_below_bat) begin
            mode_q <= bps_pkg::BPS_BACKUP;
          end
        end
        bps_pkg::BPS_BACKUP: begin
          // main above battery: switch back
          if (!cmp_s.main_below_bat) begin
            mode_q <= bps_pkg::BPS_RECOVER;
          end
        end
        bps_pkg::BPS_RECOVER: begin
          // wait out bus hold and write protect
          if (cmp_s.main_below_so && cmp_s.main_below_bat) begin
            mode_q <= bps_pkg::BPS_BACKUP;
          end else if (!bus_busy && !wp_busy && !swap_to_main) begin
            mode_q <= bps_pkg::BPS_MAIN;
          end
        end
        default: begin
          mode_q <= bps_pkg::BPS_MAIN;
        end
      endcase
    end
  end

  assign swap_to_main = (mode_q == bps_pkg::BPS_BACKUP) && !cmp_s.main_below_bat;

  // serial bus hold-off timer
  bps_timer #(.W(20)) u_bus_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(swap_to_main),
    .count(BUS_HOLD_CYCLES[19:0]),
    .busy(bus_busy),
    .done(bus_done)
  );

  // write protect recovery timer
  bps_timer #(.W(20)) u_wp_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(swap_to_main),
    .count(WP_CYCLES[19:0]),
    .busy(wp_busy),
    .done(wp_done)
  );

  // pin and function control outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      backup_mode <= 1'b0;
      pins_low <= 1'b0;
      func_gate_n <= 1'b1;
      rtc_clk_en <= 1'b1;
      input_enable <= 1'b1;
      write_protect <= 1'b0;
      serial_bus_enable <= 1'b1;
    end else begin
      backup_mode <= (mode_q == bps_pkg::BPS_BACKUP);
      pins_low <= (mode_q == bps_pkg::BPS_BACKUP);
      func_gate_n <= (mode_q != bps_pkg::BPS_BACKUP);
      rtc_clk_en <= 1'b1;
      // inputs ignored below switchover or until switched back
      input_enable <= !cmp_s.main_below_so && (mode_q != bps_pkg::BPS_BACKUP);
      write_protect <= cmp_s.main_below_so || (mode_q == bps_pkg::BPS_BACKUP)
                       || swap_to_main || wp_busy;
      serial_bus_enable <= (mode_q == bps_pkg::BPS_MAIN)
                           || ((mode_q == bps_pkg::BPS_RECOVER) && !bus_busy && !swap_to_main
                               && !bus_done && !cmp_s.main_below_so);
    end
  end

  // weekly recheck counter from rtc timebase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      week_q <= '0;
    end else if (!low_flag_q || week_tick) begin
      week_q <= '0;
    end else begin
      week_q <= week_q + 64'h1;
    end
  end
  assign week_tick = low_flag_q && (week_q == WEEK_CYCLES - 64'h1);

  // power-up check pending: set on reset and on every return to main
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_pend_q <= 1'b1;
    end else if (swap_to_main) begin
      chk_pend_q <= 1'b1;
    end else if (chk_pend_q && (mode_q == bps_pkg::BPS_MAIN) && !cmp_s.main_below_so) begin
      chk_pend_q <= 1'b0;
    end
  end

  // battery low event: power-up check or weekly recheck, gated by enable
  assign batlow_ev = bce && cmp_s.bat_low && (mode_q == bps_pkg::BPS_MAIN) && !cmp_s.main_below_so
                     && ((chk_pend_q && !low_flag_q) || week_tick);

  // low battery reported flag, cleared once battery found good
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_flag_q <= 1'b0;
    end else if (batlow_ev) begin
      low_flag_q <= 1'b1;
    end else if (!bce || (week_tick && !cmp_s.bat_low)) begin
      low_flag_q <= 1'b0;
    end
  end

  assign ev = {3{1'b0}} | ({2'b00, batlow_ev} << bps_pkg::EV_BATLOW_BIT)
              | ({2'b00, swap_to_main == 1'b0 && mode_q == bps_pkg::BPS_MAIN
                         && cmp_s.main_below_so && cmp_s.main_below_bat} << bps_pkg::EV_BACKUP_BIT)
              | ({2'b00, swap_to_main} << bps_pkg::EV_MAIN_BIT);

  // sticky status: set wins, write-one or buffer read clears
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else begin
      if (reg_rd && reg_addr == bps_pkg::ADDR_IRQBUF) begin
        stat_q <= ev;
      end else if (reg_wr && reg_addr == bps_pkg::ADDR_STAT) begin
        stat_q <= (stat_q & ~reg_wdata[2:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
    end
  end

  // control and mask writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= bps_pkg::CTRL_RST;
      mask_q <= bps_pkg::MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == bps_pkg::ADDR_CTRL) begin
        ctrl_q <= reg_wdata;
      end
      if (reg_addr == bps_pkg::ADDR_MASK) begin
        mask_q <= reg_wdata[2:0];
      end
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        bps_pkg::ADDR_CTRL: reg_rdata <= ctrl_q;
        bps_pkg::ADDR_STAT: reg_rdata <= {5'h00, stat_q};
        bps_pkg::ADDR_MASK: reg_rdata <= {5'h00, mask_q};
        bps_pkg::ADDR_IRQBUF: reg_rdata <= {5'h00, stat_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign irq_req = |(stat_q & mask_q);

  // open-drain interrupt: drive low while pending
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_o <= 1'b1;
      irq_n_oe <= 1'b0;
    end else begin
      irq_n_o <= 1'b0;
      irq_n_oe <= irq_req;
    end
  end

  a_backup_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_q == bps_pkg::BPS_MAIN) && cmp_s.main_below_so && cmp_s.main_below_bat
    |=> mode_q == bps_pkg::BPS_BACKUP) else $error("backup not entered");
  a_backup_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_q == bps_pkg::BPS_MAIN) && !(cmp_s.main_below_so && cmp_s.main_below_bat)
    |=> mode_q != bps_pkg::BPS_BACKUP) else $error("backup entered wrongly");
  a_backup_leave: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_q == bps_pkg::BPS_BACKUP) && !cmp_s.main_below_bat
    |=> mode_q == bps_pkg::BPS_RECOVER) else $error("backup not left");
  a_pins_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_q == bps_pkg::BPS_BACKUP |=> pins_low && !func_gate_n && rtc_clk_en) else $error("pins not low");
  a_inputs_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmp_s.main_below_so |=> !input_enable) else $error("inputs not ignored");
  a_wp_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    swap_to_main |=> write_protect [*8]) else $error("write protect released early");
  a_bus_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    swap_to_main |=> !serial_bus_enable [*8]) else $error("serial bus enabled early");
  a_bce_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !bce && !stat_q[bps_pkg::EV_BATLOW_BIT]
    |=> !stat_q[bps_pkg::EV_BATLOW_BIT]) else $error("battery event while disabled");
  a_irq_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_req && !(reg_rd && reg_addr == bps_pkg::ADDR_IRQBUF)
    && !(reg_wr && (reg_addr == bps_pkg::ADDR_STAT || reg_addr == bps_pkg::ADDR_MASK))
    |=> irq_n_oe) else $error("interrupt dropped without read");
  // recovery falls back to backup if the supply dips again
  a_backup_reenter: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_q == bps_pkg::BPS_RECOVER) && cmp_s.main_below_so && cmp_s.main_below_bat
    |=> mode_q == bps_pkg::BPS_BACKUP) else $error("backup not re-entered");
  // inputs come back once main is up and above switchover
  a_inputs_back: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_q == bps_pkg::BPS_MAIN) && !cmp_s.main_below_so
    |=> input_enable) else $error("inputs not resumed");
  // write protect follows the recovery timer
  a_wp_recover: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wp_busy |=> write_protect) else $error("write protect dropped in recovery");
  // serial bus stays off while the hold-off timer runs
  a_bus_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_q == bps_pkg::BPS_RECOVER) && bus_busy
    |=> !serial_bus_enable) else $error("serial bus on during hold-off");
  // a reported low battery stays remembered between rechecks
  a_low_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    low_flag_q && bce && !week_tick |=> low_flag_q) else $error("low battery flag lost");
  // pending unmasked event pulls the pin low next cycle
  a_irq_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_req |=> irq_n_oe && !irq_n_o) else $error("interrupt pin not driven");
endmodule
`default_nettype wire

// [include/bps_pkg.sv]
`default_nettype none
package bps_pkg;
  // timebase figures
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BUS_HOLD_MS = 5;
  localparam int unsigned BUS_HOLD_CYC = (CLK_HZ / 1000) * BUS_HOLD_MS;
  localparam int unsigned WP_RECOVERY_US = 100;
  localparam int unsigned WP_RECOVERY_CYC = (CLK_HZ / 1000000) * WP_RECOVERY_US;
  localparam int unsigned WEEK_S = 604800;
  localparam longint unsigned WEEK_CYC = longint'(CLK_HZ) * longint'(WEEK_S);
  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_IRQBUF = 4'h3;
  // field positions
  localparam int unsigned CTRL_BCE_BIT = 0;
  localparam int unsigned EV_BATLOW_BIT = 0;
  localparam int unsigned EV_BACKUP_BIT = 1;
  localparam int unsigned EV_MAIN_BIT = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  // supply mode state
  typedef enum logic [1:0] {
    BPS_MAIN = 2'b00,
    BPS_BACKUP = 2'b01,
    BPS_RECOVER = 2'b11
  } bps_mode_t;
  // synchronised comparator results
  typedef struct packed {
    logic main_below_so;
    logic main_below_bat;
    logic bat_low;
  } bps_cmp_t;
endpackage
`default_nettype wire

// [logic/bps_sync.sv]
`default_nettype none
// two-flop synchroniser, vector
module bps_sync #(
  parameter int W = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // first stage, read only by the second
  // two stages on the rtc clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [logic/bps_timer.sv]
`default_nettype none
// down counter: load, then done pulse when reaching zero
module bps_timer #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_q; // remaining cycles
  // load wins over counting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      cnt_q <= cnt_q - 1'b1;
      done <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
      busy <= (cnt_q != {{(W-1){1'b0}}, 1'b1});
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [tb/bps_supply_model.sv]
`default_nettype none
// supply comparators and host pull-up as the supervisor sees them
module bps_supply_model (
  input wire logic [15:0] vcc_mv,
  input wire logic [15:0] bat_mv,
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  output logic below_so,
  output logic below_bat,
  output logic bat_low,
  output logic irq_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // main below the 3500 mv switchover level
  assign below_so = vcc_mv < 16'hdac;
  // main below the battery
  assign below_bat = vcc_mv < bat_mv;
  // battery below 2500 mv
  assign bat_low = bat_mv < 16'h9c4;
  // open-drain line with host pull-up
  assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
endmodule
`default_nettype wire

// [tb/tb_bps_supervisor.sv]
`default_nettype none
// register-level bench for the supply supervisor
module tb_bps_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WK = 200;
  localparam int BH = 20;
  localparam int WP = 10;
  logic ref_clk, rst_n, wr, rd, so, bb, bl, irq_n_o, irq_n_oe, irq_line;
  logic bk, pl, fg_n, rtc_en, in_en, wp, sb_en;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] vcc, bat;
  int fails, n_checks, n1, n2;
  // device under test with short timers
  bps_supervisor #(.WEEK_CYCLES(WK), .BUS_HOLD_CYCLES(BH), .WP_CYCLES(WP)) u_bps_supervisor (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmp_main_below_so(so), .cmp_main_below_bat(bb),
    .cmp_bat_low(bl), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .backup_mode(bk),
    .pins_low(pl), .func_gate_n(fg_n), .rtc_clk_en(rtc_en), .input_enable(in_en),
    .write_protect(wp), .serial_bus_enable(sb_en));
  // comparators and host side
  bps_supply_model u_bps_supply_model (.vcc_mv(vcc), .bat_mv(bat), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe), .below_so(so), .below_bat(bb), .bat_low(bl), .irq_line(irq_line));
  // 20 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one comparison
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // idle cycles, sampling settled values
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // single-cycle register write
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // register read, data taken in the following cycle
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    check(nm, e, rdata);
  endtask
  // new supply levels in millivolts
  task automatic supply(input logic [15:0] v, input logic [15:0] b);
    @(posedge ref_clk);
    vcc <= v;
    bat <= b;
  endtask
  // bounded wait on backup_mode (0) or serial_bus_enable (1)
  task automatic wait_on(input int s, input logic v, input int n);
    int i;
    i = 0;
    while (((s == 0) ? bk : sb_en) !== v && i < n) begin
      idle(1);
      i++;
    end
    if (((s == 0) ? bk : sb_en) !== v) begin
      $display("wrong value wait %0d expected %b", s, v);
      fails++;
      stop_test();
    end
  endtask
  // dip into backup and come back with a given battery
  task automatic power_cycle(input logic [15:0] b);
    supply(16'h7d0, b);
    wait_on(0, 1'b1, 8);
    supply(16'h1388, b);
    wait_on(0, 1'b0, 8);
    wait_on(1, 1'b1, 100);
    idle(4);
  endtask
  // main sequence
  initial begin
    fails = 0;
    n_checks = 0;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    vcc = 16'h1388;
    bat = 16'hbb8;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    idle(4);
    check("levels", 8'h1d, {1'b0, bk, pl, fg_n, rtc_en, in_en, wp, sb_en});
    rd_reg(bps_pkg::ADDR_CTRL, 8'h00, "ctrl");
    rd_reg(bps_pkg::ADDR_STAT, 8'h00, "stat");
    rd_reg(4'hf, 8'h00, "unmapped");
    check("irq", 8'h01, {7'h0, irq_line});
    $display("test reset done");
    // only one of the two conditions holds
    supply(16'hd48, 16'hbb8);
    idle(8);
    check("so_only", 8'h00, {6'h0, bk, in_en});
    supply(16'he10, 16'hed8);
    idle(8);
    check("bat_only", 8'h01, {6'h0, bk, in_en});
    $display("test partial done");
    // both conditions: backup with pins low and functions gated
    supply(16'h7d0, 16'hbb8);
    wait_on(0, 1'b1, 8);
    idle(1);
    check("backup", 8'h1a, {3'h0, bk, pl, fg_n, rtc_en, in_en});
    $display("test backup done");
    // return: write protect and bus hold-off
    supply(16'hfa0, 16'hbb8);
    wait_on(0, 1'b0, 8);
    n1 = 0;
    n2 = 0;
    while (sb_en !== 1'b1 && n1 < 200) begin
      n1++;
      n2 += (wp === 1'b1);
      idle(1);
    end
    if (sb_en !== 1'b1) begin
      $display("wrong value bus_wait expected 1 seen %b", sb_en);
      fails++;
      stop_test();
    end
    check("bus_hold", 8'h01, {7'h0, n1 >= BH && n1 <= BH + 4});
    check("wp_hold", 8'h01, {7'h0, n2 >= WP && n2 <= WP + 2});
    idle(WP + 4);
    check("resume", 8'h01, {6'h0, wp, in_en});
    $display("test return done");
    // mask, write-one clear and buffer read
    rd_reg(bps_pkg::ADDR_STAT, 8'h06, "stat_ev");
    check("irq_mask", 8'h01, {7'h0, irq_line});
    wr_reg(bps_pkg::ADDR_MASK, 8'h07);
    idle(2);
    check("irq_on", 8'h00, {7'h0, irq_line});
    wr_reg(bps_pkg::ADDR_STAT, 8'h02);
    rd_reg(bps_pkg::ADDR_STAT, 8'h04, "w1c");
    check("irq_held", 8'h00, {7'h0, irq_line});
    rd_reg(bps_pkg::ADDR_IRQBUF, 8'h04, "irqbuf");
    idle(2);
    check("irq_off", 8'h01, {7'h0, irq_line});
    rd_reg(bps_pkg::ADDR_STAT, 8'h00, "stat_clr");
    $display("test irq done");
    // battery low at power-up, weekly recheck
    wr_reg(bps_pkg::ADDR_CTRL, 8'h01);
    rd_reg(bps_pkg::ADDR_CTRL, 8'h01, "ctrl_bce");
    power_cycle(16'h960);
    rd_reg(bps_pkg::ADDR_IRQBUF, 8'h07, "bat_pwrup");
    idle(40);
    rd_reg(bps_pkg::ADDR_STAT, 8'h00, "no_repeat");
    idle(WK);
    rd_reg(bps_pkg::ADDR_STAT, 8'h01, "weekly");
    supply(16'h1388, 16'hbb8);
    rd_reg(bps_pkg::ADDR_IRQBUF, 8'h01, "buf_bat");
    idle(WK + 20);
    rd_reg(bps_pkg::ADDR_STAT, 8'h00, "bat_good");
    supply(16'h1388, 16'h960);
    idle(WK + 20);
    rd_reg(bps_pkg::ADDR_STAT, 8'h00, "flag_cleared");
    // enable bit clear: no battery event
    wr_reg(bps_pkg::ADDR_CTRL, 8'h00);
    power_cycle(16'h960);
    rd_reg(bps_pkg::ADDR_IRQBUF, 8'h06, "bce_off");
    $display("test battery done");
    stop_test();
  end
endmodule
`default_nettype wire
